// >>> verilog/ejmon_pkg.sv
package ejmon_pkg;
  localparam int ADDR_W = 8;
  localparam int VAC_W = 10;
  localparam int BCD_W = 36;
  localparam int CLK_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int LEAK_PERIOD_MS = 1000;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_AIRSAVE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PARTLVL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LIMITS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_ZERO = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_VACUUM = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_DISP_SEL = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_DISP_NEXT = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_DISP = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_MEASURE = 8'h28;
  localparam int CTRL_REG_BIT = 0;
  localparam int CTRL_UNIT_LSB = 1;
  localparam int CTRL_FRST_BIT = 8;
  localparam int HI_LSB = 16;
  localparam int DISP_DP_LSB = 12;
  localparam int DISP_GRP_LSB = 16;
  localparam logic [VAC_W-1:0] DEF_SWITCH = 10'h258;
  localparam logic [VAC_W-1:0] DEF_RESUME = 10'h1f4;
  localparam logic [VAC_W-1:0] DEF_PP_ON = 10'h190;
  localparam logic [VAC_W-1:0] DEF_PP_OFF = 10'h12c;
  localparam logic [VAC_W-1:0] DEF_EVAC_LIM = 10'h000;
  localparam logic [VAC_W-1:0] DEF_LEAK_LIM = 10'h000;
  localparam logic [VAC_W-1:0] LIM_MAX = 10'h3e7;
  localparam logic DEF_REGULATED = 1'b1;
  localparam logic [2:0] GOOD_TO_CLEAR = 3'h5;
  localparam logic [9:0] SHOW_HALF_MS = 10'h1f3;
  localparam logic [11:0] SAVE_MASK = 12'h000;
  localparam logic [13:0] MUL_MBAR = 14'h0400;
  localparam logic [13:0] MUL_KPA = 14'h2800;
  localparam logic [13:0] MUL_INHG = 14'h0bd0;
  localparam logic [13:0] MUL_PSI = 14'h05cd;
  localparam int MUL_SHIFT = 10;
  localparam logic [2:0] DP_TOP = 3'h4;
  localparam logic [2:0] DP_MID = 3'h2;
  localparam logic [2:0] DP_NONE = 3'h0;
  localparam logic [1:0] LAST_GRP_CNT = 2'h2;
  localparam logic [1:0] LAST_GRP_PART = 2'h3;
  typedef enum logic [1:0] {
    UNIT_MBAR = 2'b00,
    UNIT_KPA = 2'b01,
    UNIT_INHG = 2'b10,
    UNIT_PSI = 2'b11
  } ejmon_unit_type;
  localparam ejmon_unit_type DEF_UNIT = UNIT_MBAR;
  typedef enum logic [1:0] {
    ITEM_CC1 = 2'b00,
    ITEM_CC2 = 2'b01,
    ITEM_PART = 2'b10,
    ITEM_SERIAL = 2'b11
  } ejmon_item_type;
  typedef enum logic {
    MS_IDLE = 1'b0,
    MS_RUN = 1'b1
  } ejmon_meas_type;
endpackage

// >>> verilog/ejmon_top.sv
// Our own choices: the APB register port and the address map.
module ejmon_top #(
  parameter int MS_CYCLES = ejmon_pkg::MS_NS / ejmon_pkg::CLK_NS,
  // Arbitrary identity values, BCD
  parameter logic [43:0] PART_NUMBER = 44'h12345678901,
  parameter logic [35:0] SERIAL_NUMBER = 36'h123456789
) (
  input wire logic I_MCLK,
  input wire logic I_SRST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ejmon_pkg::ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic I_SUCTION_CMD,
  input wire logic [ejmon_pkg::VAC_W-1:0] I_VAC_RAW,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic O_VALVE_ON,
  output logic O_PART_PRESENT,
  output logic O_EVAC_ERR,
  output logic O_LEAK_ERR,
  output logic O_ERR_SHOW,
  output logic [1:0] O_NV_SAVE,
  output logic [ejmon_pkg::BCD_W-1:0] O_NV_CC1,
  output logic [ejmon_pkg::BCD_W-1:0] O_NV_CC2
);
  localparam int VW = ejmon_pkg::VAC_W;
  localparam int BW = ejmon_pkg::BCD_W;

  // Nine BCD digits: counts straight to 999999999 with no binary divider
  function automatic logic [BW-1:0] bcd_inc(input logic [BW-1:0] v);
    logic c;
    logic [BW-1:0] r;
    c = 1'b1;
    r = v;
    for (int d = 0; d < BW / 4; d++) begin
      if (c) begin
        if (v[4*d +: 4] == 4'h9) begin
          r[4*d +: 4] = 4'h0;
        end else begin
          r[4*d +: 4] = v[4*d +: 4] + 4'h1;
          c = 1'b0;
        end
      end
    end
    return r;
  endfunction

  // Configuration
  logic regulated, next_regulated;
  ejmon_pkg::ejmon_unit_type unit, next_unit;
  logic [VW-1:0] sw_lvl, next_sw_lvl, rs_lvl, next_rs_lvl;
  logic [VW-1:0] pp_on, next_pp_on, pp_off, next_pp_off;
  logic [VW-1:0] evac_lim, next_evac_lim, leak_lim, next_leak_lim;
  logic [VW-1:0] zero_ofs, next_zero_ofs;
  ejmon_pkg::ejmon_item_type item, next_item;
  logic [1:0] grp, next_grp;
  logic [31:0] next_prdata;
  logic next_pready;
  logic wr_acc, rd_set;

  assign wr_acc = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;

  always_comb begin
    next_regulated = regulated;
    next_unit = unit;
    next_sw_lvl = sw_lvl;
    next_rs_lvl = rs_lvl;
    next_pp_on = pp_on;
    next_pp_off = pp_off;
    next_evac_lim = evac_lim;
    next_leak_lim = leak_lim;
    next_zero_ofs = zero_ofs;
    next_item = item;
    next_grp = grp;
    next_pready = I_PSEL && I_PENABLE && !O_PREADY;
    if (wr_acc) begin
      case (I_PADDR)
        ejmon_pkg::OFS_CTRL: begin
          if (I_PWDATA[ejmon_pkg::CTRL_FRST_BIT]) begin
            // Counters and zero offset deliberately left alone
            next_regulated = ejmon_pkg::DEF_REGULATED;
            next_unit = ejmon_pkg::DEF_UNIT;
            next_sw_lvl = ejmon_pkg::DEF_SWITCH;
            next_rs_lvl = ejmon_pkg::DEF_RESUME;
            next_pp_on = ejmon_pkg::DEF_PP_ON;
            next_pp_off = ejmon_pkg::DEF_PP_OFF;
            next_evac_lim = ejmon_pkg::DEF_EVAC_LIM;
            next_leak_lim = ejmon_pkg::DEF_LEAK_LIM;
          end else begin
            next_regulated = I_PWDATA[ejmon_pkg::CTRL_REG_BIT];
            next_unit = ejmon_pkg::ejmon_unit_type'(
              I_PWDATA[ejmon_pkg::CTRL_UNIT_LSB +: 2]);
          end
        end
        ejmon_pkg::OFS_AIRSAVE: begin
          next_sw_lvl = I_PWDATA[VW-1:0];
          next_rs_lvl = I_PWDATA[ejmon_pkg::HI_LSB +: VW];
        end
        ejmon_pkg::OFS_PARTLVL: begin
          next_pp_on = I_PWDATA[VW-1:0];
          next_pp_off = I_PWDATA[ejmon_pkg::HI_LSB +: VW];
        end
        ejmon_pkg::OFS_LIMITS: begin
          // Out-of-range limits saturate at the top setting
          next_evac_lim = (I_PWDATA[VW-1:0] > ejmon_pkg::LIM_MAX) ?
            ejmon_pkg::LIM_MAX : I_PWDATA[VW-1:0];
          next_leak_lim =
            (I_PWDATA[ejmon_pkg::HI_LSB +: VW] > ejmon_pkg::LIM_MAX) ?
            ejmon_pkg::LIM_MAX : I_PWDATA[ejmon_pkg::HI_LSB +: VW];
        end
        ejmon_pkg::OFS_ZERO: next_zero_ofs = I_PWDATA[VW-1:0];
        ejmon_pkg::OFS_DISP_SEL: begin
          next_item = ejmon_pkg::ejmon_item_type'(I_PWDATA[1:0]);
          next_grp = 2'h0;
        end
        ejmon_pkg::OFS_DISP_NEXT: begin
          // Wraps back to the top group after the last one
          if (grp == ((item == ejmon_pkg::ITEM_PART) ?
              ejmon_pkg::LAST_GRP_PART : ejmon_pkg::LAST_GRP_CNT)) begin
            next_grp = 2'h0;
          end else begin
            next_grp = grp + 2'h1;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      regulated <= ejmon_pkg::DEF_REGULATED;
      unit <= ejmon_pkg::DEF_UNIT;
      sw_lvl <= ejmon_pkg::DEF_SWITCH;
      rs_lvl <= ejmon_pkg::DEF_RESUME;
      pp_on <= ejmon_pkg::DEF_PP_ON;
      pp_off <= ejmon_pkg::DEF_PP_OFF;
      evac_lim <= ejmon_pkg::DEF_EVAC_LIM;
      leak_lim <= ejmon_pkg::DEF_LEAK_LIM;
      zero_ofs <= '0;
      item <= ejmon_pkg::ITEM_CC1;
      grp <= 2'h0;
      O_PREADY <= 1'b0;
      O_PRDATA <= '0;
      O_PSLVERR <= 1'b0;
    end else begin
      regulated <= next_regulated;
      unit <= next_unit;
      sw_lvl <= next_sw_lvl;
      rs_lvl <= next_rs_lvl;
      pp_on <= next_pp_on;
      pp_off <= next_pp_off;
      evac_lim <= next_evac_lim;
      leak_lim <= next_leak_lim;
      zero_ofs <= next_zero_ofs;
      item <= next_item;
      grp <= next_grp;
      O_PREADY <= next_pready;
      O_PRDATA <= next_prdata;
      O_PSLVERR <= 1'b0;
    end
  end

  // Vacuum after zero-point correction, floored at zero
  logic [VW-1:0] vac;
  assign vac = (I_VAC_RAW > zero_ofs) ? I_VAC_RAW - zero_ofs : '0;

  // Air-saving regulation, part-present and counters
  logic hold, next_hold, next_valve, next_pp, cmd_d, next_cmd_d;
  logic [BW-1:0] cc1, next_cc1, cc2, next_cc2;
  logic [BW-1:0] next_nv1, next_nv2;
  logic [1:0] next_save;

  always_comb begin
    next_cmd_d = I_SUCTION_CMD;
    next_hold = hold;
    if (!I_SUCTION_CMD || !regulated || vac < rs_lvl) begin
      next_hold = 1'b0;
    end else if (vac >= sw_lvl) begin
      next_hold = 1'b1;
    end
    next_valve = I_SUCTION_CMD && !next_hold;
    next_pp = O_PART_PRESENT;
    if (vac >= pp_on) begin
      next_pp = 1'b1;
    end else if (vac < pp_off) begin
      next_pp = 1'b0;
    end
    // No write path reaches the counters at all
    next_cc1 = (I_SUCTION_CMD && !cmd_d) ? bcd_inc(cc1) : cc1;
    next_cc2 = (next_valve && !O_VALVE_ON) ? bcd_inc(cc2) : cc2;
    next_save = 2'b00;
    next_nv1 = O_NV_CC1;
    next_nv2 = O_NV_CC2;
    if (next_cc1 != cc1 && next_cc1[11:0] == ejmon_pkg::SAVE_MASK) begin
      next_save[0] = 1'b1;
      next_nv1 = next_cc1;
    end
    if (next_cc2 != cc2 && next_cc2[11:0] == ejmon_pkg::SAVE_MASK) begin
      next_save[1] = 1'b1;
      next_nv2 = next_cc2;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      hold <= 1'b0;
      cmd_d <= 1'b0;
      O_VALVE_ON <= 1'b0;
      O_PART_PRESENT <= 1'b0;
      cc1 <= '0;
      cc2 <= '0;
      O_NV_SAVE <= 2'b00;
      O_NV_CC1 <= '0;
      O_NV_CC2 <= '0;
    end else begin
      hold <= next_hold;
      cmd_d <= next_cmd_d;
      O_VALVE_ON <= next_valve;
      O_PART_PRESENT <= next_pp;
      cc1 <= next_cc1;
      cc2 <= next_cc2;
      O_NV_SAVE <= next_save;
      O_NV_CC1 <= next_nv1;
      O_NV_CC2 <= next_nv2;
    end
  end

  // Millisecond tick and condition monitoring
  logic [31:0] tick_cnt, next_tick_cnt;
  logic ms_tick;
  ejmon_pkg::ejmon_meas_type ev_st, next_ev_st, lk_st, next_lk_st;
  logic [13:0] ev_ms, next_ev_ms, ev_last, next_ev_last, ev_lim_ms;
  logic [VW-1:0] lk_ms, next_lk_ms, lk_start, next_lk_start;
  logic [VW-1:0] lk_drop, lk_last, next_lk_last;
  logic [2:0] ev_good, next_ev_good, lk_good, next_lk_good;
  logic next_evac_err, next_leak_err, lk_end, next_show;
  logic [9:0] show_cnt, next_show_cnt;

  assign ms_tick = (tick_cnt == 32'(MS_CYCLES - 1));
  assign ev_lim_ms = 14'({evac_lim, 3'b000}) + 14'({evac_lim, 1'b0});
  assign lk_drop = (lk_start > vac) ? lk_start - vac : '0;
  assign lk_end = (lk_ms == VW'(ejmon_pkg::LEAK_PERIOD_MS)) || !next_hold;

  always_comb begin
    next_tick_cnt = ms_tick ? 32'h0 : tick_cnt + 32'h1;
    next_ev_st = ev_st;
    next_ev_ms = ev_ms;
    next_ev_last = ev_last;
    next_ev_good = ev_good;
    next_evac_err = O_EVAC_ERR;
    case (ev_st)
      ejmon_pkg::MS_IDLE: begin
        if (I_SUCTION_CMD && next_pp && !O_PART_PRESENT) begin
          next_ev_st = ejmon_pkg::MS_RUN;
          next_ev_ms = 14'h0;
        end
      end
      ejmon_pkg::MS_RUN: begin
        // Saturates so a stalled interval still reads as too long
        if (ms_tick && ev_ms != '1) begin
          next_ev_ms = ev_ms + 14'h1;
        end
        if (!I_SUCTION_CMD || !O_PART_PRESENT) begin
          next_ev_st = ejmon_pkg::MS_IDLE;
        end else if (vac >= sw_lvl) begin
          next_ev_st = ejmon_pkg::MS_IDLE;
          next_ev_last = ev_ms;
          if (evac_lim != '0 && ev_ms > ev_lim_ms) begin
            next_evac_err = 1'b1;
            next_ev_good = 3'h0;
          end else if (O_EVAC_ERR) begin
            next_ev_good = ev_good + 3'h1;
            if (next_ev_good == ejmon_pkg::GOOD_TO_CLEAR) begin
              next_evac_err = 1'b0;
              next_ev_good = 3'h0;
            end
          end
        end
      end
      default: next_ev_st = ejmon_pkg::MS_IDLE;
    endcase
    if (evac_lim == '0) begin
      next_evac_err = 1'b0;
      next_ev_good = 3'h0;
    end
    next_lk_st = lk_st;
    next_lk_ms = lk_ms;
    next_lk_start = lk_start;
    next_lk_last = lk_last;
    next_lk_good = lk_good;
    next_leak_err = O_LEAK_ERR;
    case (lk_st)
      ejmon_pkg::MS_IDLE: begin
        if (regulated && next_hold && !hold) begin
          next_lk_st = ejmon_pkg::MS_RUN;
          next_lk_ms = '0;
          next_lk_start = vac;
        end
      end
      ejmon_pkg::MS_RUN: begin
        if (ms_tick) begin
          next_lk_ms = lk_ms + VW'(1);
        end
        if (!I_SUCTION_CMD) begin
          next_lk_st = ejmon_pkg::MS_IDLE;
        end else if (lk_end) begin
          // Early resume counts the drop so far as the per-second rate
          next_lk_st = ejmon_pkg::MS_IDLE;
          next_lk_last = lk_drop;
          if (leak_lim != '0 && lk_drop > leak_lim) begin
            next_leak_err = 1'b1;
            next_lk_good = 3'h0;
          end else if (O_LEAK_ERR && lk_drop < leak_lim) begin
            next_lk_good = lk_good + 3'h1;
            if (next_lk_good == ejmon_pkg::GOOD_TO_CLEAR) begin
              next_leak_err = 1'b0;
              next_lk_good = 3'h0;
            end
          end
        end
      end
      default: next_lk_st = ejmon_pkg::MS_IDLE;
    endcase
    if (leak_lim == '0) begin
      next_leak_err = 1'b0;
      next_lk_good = 3'h0;
    end
    // Half-second toggle alternates error code and vacuum on the display
    next_show_cnt = show_cnt;
    next_show = O_ERR_SHOW;
    if (!(next_evac_err || next_leak_err)) begin
      next_show_cnt = '0;
      next_show = 1'b0;
    end else if (ms_tick) begin
      next_show_cnt = show_cnt + 10'h1;
      if (show_cnt == ejmon_pkg::SHOW_HALF_MS) begin
        next_show_cnt = '0;
        next_show = !O_ERR_SHOW;
      end
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      tick_cnt <= '0;
      ev_st <= ejmon_pkg::MS_IDLE;
      ev_ms <= '0;
      ev_last <= '0;
      ev_good <= '0;
      O_EVAC_ERR <= 1'b0;
      lk_st <= ejmon_pkg::MS_IDLE;
      lk_ms <= '0;
      lk_start <= '0;
      lk_last <= '0;
      lk_good <= '0;
      O_LEAK_ERR <= 1'b0;
      show_cnt <= '0;
      O_ERR_SHOW <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      ev_st <= next_ev_st;
      ev_ms <= next_ev_ms;
      ev_last <= next_ev_last;
      ev_good <= next_ev_good;
      O_EVAC_ERR <= next_evac_err;
      lk_st <= next_lk_st;
      lk_ms <= next_lk_ms;
      lk_start <= next_lk_start;
      lk_last <= next_lk_last;
      lk_good <= next_lk_good;
      O_LEAK_ERR <= next_leak_err;
      show_cnt <= next_show_cnt;
      O_ERR_SHOW <= next_show;
    end
  end

  // Unit conversion, hundredths of kPa, inHg and psi; mbar whole
  logic [13:0] mul;
  logic [23:0] prod;
  logic [11:0] digits;
  logic [2:0] dp;
  always_comb begin
    case (unit)
      ejmon_pkg::UNIT_KPA: mul = ejmon_pkg::MUL_KPA;
      ejmon_pkg::UNIT_INHG: mul = ejmon_pkg::MUL_INHG;
      ejmon_pkg::UNIT_PSI: mul = ejmon_pkg::MUL_PSI;
      default: mul = ejmon_pkg::MUL_MBAR;
    endcase
    prod = 24'(vac) * 24'(mul);
    dp = (grp == 2'h0) ? ejmon_pkg::DP_TOP :
         (grp == 2'h1) ? ejmon_pkg::DP_MID : ejmon_pkg::DP_NONE;
    case (item)
      ejmon_pkg::ITEM_CC1: digits = cc1[BW-1-12*grp -: 12];
      ejmon_pkg::ITEM_CC2: digits = cc2[BW-1-12*grp -: 12];
      ejmon_pkg::ITEM_SERIAL: digits = SERIAL_NUMBER[BW-1-12*grp -: 12];
      default: begin
        digits = (grp == 2'h0) ? {4'h0, PART_NUMBER[43:36]} :
                 PART_NUMBER[47-12*grp -: 12];
        dp = (grp == 2'h1) ? ejmon_pkg::DP_MID :
             (grp == 2'h2) ? ejmon_pkg::DP_TOP : ejmon_pkg::DP_NONE;
      end
    endcase
    next_prdata = '0;
    rd_set = I_PSEL && I_PENABLE && !O_PREADY && !I_PWRITE;
    if (rd_set) begin
      case (I_PADDR)
        ejmon_pkg::OFS_CTRL: next_prdata = 32'({unit, regulated});
        ejmon_pkg::OFS_AIRSAVE: next_prdata = {6'h0, rs_lvl, 6'h0, sw_lvl};
        ejmon_pkg::OFS_PARTLVL: next_prdata = {6'h0, pp_off, 6'h0, pp_on};
        ejmon_pkg::OFS_LIMITS:
          next_prdata = {6'h0, leak_lim, 6'h0, evac_lim};
        ejmon_pkg::OFS_ZERO: next_prdata = 32'(zero_ofs);
        ejmon_pkg::OFS_STATUS: next_prdata = 32'({O_ERR_SHOW, O_LEAK_ERR,
          O_EVAC_ERR, hold, O_PART_PRESENT, O_VALVE_ON});
        ejmon_pkg::OFS_VACUUM:
          next_prdata = 32'(prod[ejmon_pkg::MUL_SHIFT +: 14]);
        ejmon_pkg::OFS_DISP_SEL: next_prdata = 32'(item);
        ejmon_pkg::OFS_DISP:
          next_prdata = 32'({grp, 1'b0, dp, digits});
        ejmon_pkg::OFS_MEASURE:
          next_prdata = {6'h0, lk_last, 2'h0, ev_last};
        default: next_prdata = '0;
      endcase
    end
  end

  property p_cc_up;
    @(posedge I_MCLK) disable iff (I_SRST)
    cc1 != $past(cc1) |-> cc1 == bcd_inc($past(cc1));
  endproperty
  a_cc_up: assert property (p_cc_up) else $error("cc1 bad step");

  property p_cc1_inc;
    @(posedge I_MCLK) disable iff (I_SRST)
    $rose(I_SUCTION_CMD) |=> cc1 == bcd_inc($past(cc1));
  endproperty
  a_cc1_inc: assert property (p_cc1_inc) else $error("cc1 missed");

  property p_cc2_inc;
    @(posedge I_MCLK) disable iff (I_SRST)
    $rose(O_VALVE_ON) |-> cc2 == bcd_inc($past(cc2));
  endproperty
  a_cc2_inc: assert property (p_cc2_inc) else $error("cc2 missed");

  property p_nv_step;
    @(posedge I_MCLK) disable iff (I_SRST)
    O_NV_SAVE[0] |-> O_NV_CC1[11:0] == 12'h000 && O_NV_CC1 == cc1;
  endproperty
  a_nv_step: assert property (p_nv_step) else $error("bad save");

  property p_evac_off;
    @(posedge I_MCLK) disable iff (I_SRST)
    evac_lim == '0 |=> !O_EVAC_ERR;
  endproperty
  a_evac_off: assert property (p_evac_off) else $error("evac err");

  property p_leak_off;
    @(posedge I_MCLK) disable iff (I_SRST)
    leak_lim == '0 |=> !O_LEAK_ERR;
  endproperty
  a_leak_off: assert property (p_leak_off) else $error("leak err");

  property p_stop;
    @(posedge I_MCLK) disable iff (I_SRST)
    regulated && vac >= sw_lvl && vac >= rs_lvl
      ##1 regulated && vac >= rs_lvl |-> ##1 !O_VALVE_ON;
  endproperty
  a_stop: assert property (p_stop) else $error("valve not off");

  property p_frst;
    @(posedge I_MCLK) disable iff (I_SRST)
    wr_acc && I_PADDR == ejmon_pkg::OFS_CTRL &&
      I_PWDATA[ejmon_pkg::CTRL_FRST_BIT]
      |=> zero_ofs == $past(zero_ofs) && evac_lim == '0;
  endproperty
  a_frst: assert property (p_frst) else $error("factory reset");

  property p_pp;
    @(posedge I_MCLK) disable iff (I_SRST)
    vac >= pp_on |=> O_PART_PRESENT;
  endproperty
  a_pp: assert property (p_pp) else $error("part present");

  property p_part_dp;
    @(posedge I_MCLK) disable iff (I_SRST)
    item == ejmon_pkg::ITEM_PART && grp == 2'h0 && rd_set &&
      I_PADDR == ejmon_pkg::OFS_DISP |=> O_PRDATA[14:12] == 3'h0;
  endproperty
  a_part_dp: assert property (p_part_dp) else $error("part dp");
endmodule

// >>> testbench/ejmon_ctl_model.sv
module ejmon_ctl_model (
  input wire logic i_clk,
  output logic o_suction,
  output logic [9:0] o_vac
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_suction = 1'b0;
    o_vac = 10'h000;
  end
  task automatic set_vac(input logic [9:0] v);
    o_vac <= v;
  endtask
  // Sealed part: stop at switch level, then leak to a lower level
  task automatic leak_cycle(input logic [9:0] low);
    @(posedge i_clk);
    o_suction <= 1'b1;
    o_vac <= 10'h28a;
    repeat (3) @(posedge i_clk);
    o_vac <= low;
    repeat (3) @(posedge i_clk);
    o_suction <= 1'b0;
    o_vac <= 10'h000;
    repeat (3) @(posedge i_clk);
  endtask
  // Plant jumps past part level, dwells, then past switch level
  task automatic run_cycle(input int dwell_cyc);
    @(posedge i_clk);
    o_suction <= 1'b1;
    repeat (3) @(posedge i_clk);
    o_vac <= 10'h1c2;
    repeat (dwell_cyc) @(posedge i_clk);
    o_vac <= 10'h28a;
    repeat (5) @(posedge i_clk);
    o_suction <= 1'b0;
    // Released circuit vents to atmosphere, not last value
    o_vac <= 10'h000;
    repeat (5) @(posedge i_clk);
  endtask
endmodule

// >>> testbench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, psel, pen, pwr, suc, pready, evac_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [9:0] vac;
  logic pp, valve, leak_err, show, pslverr;
  logic [35:0] nv1, nv2;
  int n_fail, n_compared;
  logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h30};
  logic [31:0] re [6] = '{32'h1, 32'h01f40258, 32'h012c0190, 0, 0, 0};
  ejmon_ctl_model m (.i_clk(clk), .o_suction(suc), .o_vac(vac));
  ejmon_top #(.MS_CYCLES(10)) dut (.I_MCLK(clk), .I_SRST(srst),
    .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .I_SUCTION_CMD(suc), .I_VAC_RAW(vac),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .O_VALVE_ON(valve), .O_PART_PRESENT(pp), .O_EVAC_ERR(evac_err),
    .O_LEAK_ERR(leak_err), .O_ERR_SHOW(show), .O_NV_SAVE(),
    .O_NV_CC1(nv1), .O_NV_CC2(nv2));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic final_report();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite_set(w);
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      final_report();
    end
    r = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic pwrite_set(input logic w);
    pwr <= w;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk($sformatf("reg %h", a), e, r);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic err_is(input logic e);
    repeat (2) @(posedge clk);
    chk("evac_err", {31'h0, e}, {31'h0, evac_err});
  endtask
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 6; i++) rd(ra[i], re[i]);
    m.set_vac(10'h1f4);
    repeat (3) @(posedge clk);
    rd(8'h18, 32'h1f4);
    chk("pp", 32'h1, {31'h0, pp});
    chk("valve", 32'h0, {31'h0, valve});
    rd(8'h14, 32'h2);
    chk("pslverr", 32'h0, {31'h0, pslverr});
    wr(8'h00, 32'h3);
    rd(8'h18, 32'h1388);
    wr(8'h00, 32'h1);
    m.set_vac(10'h000);
    wr(8'h0c, 32'h1);
    m.run_cycle(300);
    err_is(1'b1);
    wr(8'h0c, 32'h0);
    err_is(1'b0);
    wr(8'h0c, 32'h1);
    m.run_cycle(300);
    err_is(1'b1);
    // Four good intervals must not yet clear the error
    repeat (4) m.run_cycle(20);
    err_is(1'b1);
    m.run_cycle(20);
    err_is(1'b0);
    wr(8'h04, 32'h00640064);
    wr(8'h10, 32'h5);
    wr(8'h00, 32'h100);
    rd(8'h04, 32'h01f40258);
    rd(8'h10, 32'h5);
    for (int k = 0; k < 2; k++) begin
      wr(8'h1c, k);
      rd(8'h24, 32'h4000);
      wr(8'h20, 32'h0);
      wr(8'h20, 32'h0);
      rd(8'h24, 32'h20007);
    end
    wr(8'h1c, 32'h3);
    rd(8'h24, 32'h4123);
    wr(8'h1c, 32'h2);
    rd(8'h24, 32'h012);
    wr(8'h20, 32'h0);
    rd(8'h24, 32'h12345);
    // Seven cycles so far; 993 more reach the first save point
    repeat (993) m.run_cycle(1);
    chk("nv_cc1", 32'h1000, nv1[31:0]);
    chk("nv_cc2", 32'h1000, nv2[31:0]);
    wr(8'h0c, 32'h00c80000);
    m.leak_cycle(10'h195);
    chk("leak_err", 32'h1, {31'h0, leak_err});
    rd(8'h28, 32'h00f50000);
    repeat (4) m.leak_cycle(10'h1ef);
    chk("leak_err", 32'h1, {31'h0, leak_err});
    m.leak_cycle(10'h1ef);
    chk("leak_err", 32'h0, {31'h0, leak_err});
    chk("err_show", 32'h0, {31'h0, show});
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    chk("nv_cc1 rst", 32'h0, nv1[31:0]);
    rd(8'h10, 32'h0);
    final_report();
  end
endmodule
